// ### core/intc_pkg.sv
package intc_pkg;

    localparam int          NUM_SRC    = 54;
    localparam int          PRIO_WORDS = 7;
    localparam logic [5:0]  VEC_BASE   = 6'h08;
    localparam logic [53:0] SRC_IMPL   = 54'h0000067FFFFFFFFF;
    localparam logic [31:0] PRIO_RESET = 32'h44444444;
    localparam logic [31:0] PRIO_FIELD = 32'h77777777;

    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

    // Register byte offsets
    localparam logic [7:0] OFS_FLAG_LO   = 8'h00;
    localparam logic [7:0] OFS_FLAG_HI   = 8'h04;
    localparam logic [7:0] OFS_EN_LO     = 8'h08;
    localparam logic [7:0] OFS_EN_HI     = 8'h0C;
    localparam logic [7:0] OFS_PRIO_BASE = 8'h10;
    localparam logic [7:0] OFS_PRIO_LAST = 8'h28;
    localparam logic [7:0] OFS_TRAP_CTRL = 8'h2C;
    localparam logic [7:0] OFS_TRAP_STAT = 8'h30;
    localparam logic [7:0] OFS_RST_CAUSE = 8'h34;
    localparam logic [7:0] OFS_CORE_STAT = 8'h38;

    // Field positions
    localparam int HI_WIDTH       = 22;
    localparam int CTRL_OVF31_BIT = 0;
    localparam int CTRL_OVF39_BIT = 1;
    localparam int STAT_MATH_BIT  = 0;
    localparam int STAT_ADDR_BIT  = 1;
    localparam int CAUSE_WIDTH    = 6;
    localparam int CS_CPU_LSB     = 0;
    localparam int CS_LEVEL_LSB   = 4;
    localparam int CS_VEC_LSB     = 8;
    localparam int CS_IRQ_BIT     = 16;
    localparam int CS_TRAP_BIT    = 17;

    localparam logic [1:0] CTRL_RESET = 2'h0;

    // Trap vectors sit in the low vector slots; level is vector plus 8
    localparam logic [5:0] MATH_TRAP_VEC = 6'h03;
    localparam logic [5:0] ADDR_TRAP_VEC = 6'h04;
    localparam logic [3:0] TRAP_LEVEL_BASE = 4'h8;

    typedef enum logic [2:0] {
        TRAP_IDLE = 3'b001,
        TRAP_WAIT = 3'b010,
        TRAP_SHOW = 3'b100
    } trap_state_e;

    // Reserved nibbles of a priority word read back as zero
    function automatic logic [31:0] prio_mask(input int w);
        logic [31:0] m;
        int          src;
        m = 32'h00000000;
        for (int n = 0; n < 8; n++) begin
            src = w * 8 + n;
            if (src < NUM_SRC && SRC_IMPL[src]) begin
                m[n*4 +: 3] = 3'h7;
            end
        end
        return m;
    endfunction : prio_mask

    function automatic logic [3:0] trap_level_of(input logic [5:0] vec);
        return TRAP_LEVEL_BASE | {1'b0, vec[2:0]};
    endfunction : trap_level_of

endpackage : intc_pkg

// ### core/interrupt_trap_priority.sv
`timescale 1ns/1ps
module interrupt_trap_priority (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Peripheral request events
    input  wire logic [53:0] irq_event,
    // Core state and error indications
    input  wire logic [3:0]  cpu_priority_level,
    input  wire logic        insn_boundary,
    input  wire logic        trap_ack,
    input  wire logic        watchdog_timeout,
    input  wire logic        uninit_wreg_pointer,
    input  wire logic        illegal_op_exec,
    input  wire logic        illegal_op_flushed,
    input  wire logic        brownout_reset,
    input  wire logic        soft_reset_op,
    input  wire logic        div_by_zero,
    input  wire logic [1:0]  acc_ovf31,
    input  wire logic        guard_bits_used,
    input  wire logic [1:0]  acc_ovf39,
    input  wire logic        saturation_disabled,
    input  wire logic        shift_overrange,
    input  wire logic        misaligned_word,
    input  wire logic        unimpl_data_fetch,
    input  wire logic        unimpl_prog_fetch,
    input  wire logic        vector_space_fetch,
    input  wire logic        multiply_accumulate_class,
    input  wire logic        x_access_in_y,
    input  wire logic        y_access_in_x,
    input  wire logic        jump_to_unimpl,
    input  wire logic        exec_unimpl_pc,
    input  wire logic        invalid_vector,
    // To the core
    output logic             irq_valid,
    output logic [5:0]       irq_vector,
    output logic [3:0]       irq_level,
    output logic             trap_valid,
    output logic [5:0]       trap_vector,
    output logic [3:0]       trap_level,
    output logic             reset_request
);

    logic [53:0]             flag_reg;
    logic [53:0]             flag_next;
    logic [53:0]             enable_reg;
    logic [53:0]             enable_next;
    logic [6:0][31:0]        prio_reg;
    logic [1:0]              ctrl_reg;
    logic [1:0]              trap_stat_reg;
    logic [1:0]              trap_stat_next;
    logic [5:0]              cause_reg;
    logic [5:0]              cause_next;
    logic                    math_pend_reg;
    logic                    math_pend_next;
    logic                    addr_pend_reg;
    logic                    addr_pend_next;
    intc_pkg::trap_state_e   trap_state_reg;
    intc_pkg::trap_state_e   trap_state_next;
    logic [7:0]              addr_reg;
    logic                    wr_pend_reg;
    logic [31:0]             hrdata_reg;
    logic                    hreadyout_reg;
    logic                    hresp_reg;
    logic                    irq_valid_reg;
    logic [5:0]              irq_vector_reg;
    logic [3:0]              irq_level_reg;
    logic                    trap_valid_reg;
    logic [5:0]              trap_vector_reg;
    logic                    reset_request_reg;

    // Bus address phase and write decode
    wire bus_take = hsel && hready && htrans == intc_pkg::HTRANS_NONSEQ;
    wire wr_flag_lo = wr_pend_reg && addr_reg == intc_pkg::OFS_FLAG_LO;
    wire wr_flag_hi = wr_pend_reg && addr_reg == intc_pkg::OFS_FLAG_HI;
    wire wr_en_lo   = wr_pend_reg && addr_reg == intc_pkg::OFS_EN_LO;
    wire wr_en_hi   = wr_pend_reg && addr_reg == intc_pkg::OFS_EN_HI;
    wire wr_ctrl    = wr_pend_reg && addr_reg == intc_pkg::OFS_TRAP_CTRL;
    wire wr_stat    = wr_pend_reg && addr_reg == intc_pkg::OFS_TRAP_STAT;
    wire wr_cause   = wr_pend_reg && addr_reg == intc_pkg::OFS_RST_CAUSE;
    wire wr_prio    = wr_pend_reg && addr_reg >= intc_pkg::OFS_PRIO_BASE
                      && addr_reg <= intc_pkg::OFS_PRIO_LAST;
    wire [7:0] prio_wofs = addr_reg - intc_pkg::OFS_PRIO_BASE;
    wire [2:0] prio_widx = prio_wofs[4:2];

    // Read selection, taken from the address phase
    wire [7:0] rd_addr  = haddr[7:0];
    wire [7:0] rd_pofs  = rd_addr - intc_pkg::OFS_PRIO_BASE;
    wire [2:0] rd_pidx  = rd_pofs[4:2];
    wire       rd_prio  = rd_addr >= intc_pkg::OFS_PRIO_BASE
                          && rd_addr <= intc_pkg::OFS_PRIO_LAST
                          && rd_addr[1:0] == 2'h0;
    wire       rd_upper = haddr[31:8] != 24'h000000;
    wire [31:0] prio_rd_value;
    wire [31:0] core_stat_value;
    wire [31:0] read_value;

    // Masks built per word once, reused on read
    logic [6:0][31:0] prio_masked;
    genvar w;
    generate
        for (w = 0; w < intc_pkg::PRIO_WORDS; w++) begin : g_prio
            assign prio_masked[w] = prio_reg[w] & intc_pkg::prio_mask(w);

            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    prio_reg[w] <= intc_pkg::PRIO_RESET;
                end else if (clk_en && wr_prio && prio_widx == 3'(w)) begin
                    prio_reg[w] <= hwdata & intc_pkg::PRIO_FIELD;
                end
            end
        end
    endgenerate

    assign prio_rd_value = prio_masked[rd_pidx];

    assign core_stat_value =
        (32'(cpu_priority_level) << intc_pkg::CS_CPU_LSB)
        | (32'(irq_level_reg)    << intc_pkg::CS_LEVEL_LSB)
        | (32'(irq_vector_reg)   << intc_pkg::CS_VEC_LSB)
        | (32'(irq_valid_reg)    << intc_pkg::CS_IRQ_BIT)
        | (32'(trap_valid_reg)   << intc_pkg::CS_TRAP_BIT);

    // Unmapped offsets read zero and still answer OKAY
    assign read_value =
        rd_upper ? 32'h00000000 :
        rd_prio  ? prio_rd_value :
        rd_addr == intc_pkg::OFS_FLAG_LO ? flag_reg[31:0] :
        rd_addr == intc_pkg::OFS_FLAG_HI ? 32'(flag_reg[53:32]) :
        rd_addr == intc_pkg::OFS_EN_LO   ? enable_reg[31:0] :
        rd_addr == intc_pkg::OFS_EN_HI   ? 32'(enable_reg[53:32]) :
        rd_addr == intc_pkg::OFS_TRAP_CTRL ? 32'(ctrl_reg) :
        rd_addr == intc_pkg::OFS_TRAP_STAT ? 32'(trap_stat_reg) :
        rd_addr == intc_pkg::OFS_RST_CAUSE ? 32'(cause_reg) :
        rd_addr == intc_pkg::OFS_CORE_STAT ? core_stat_value :
        32'h00000000;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_reg    <= 8'h00;
            wr_pend_reg <= 1'b0;
            hrdata_reg  <= 32'h00000000;
        end else if (clk_en) begin
            wr_pend_reg <= bus_take && hwrite && !rd_upper;
            addr_reg    <= haddr[7:0];
            if (bus_take && !hwrite) begin
                hrdata_reg <= read_value;
            end
        end
    end

    // Zero wait states; the slave never errors
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end else if (clk_en) begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end
    end

    // Request flags: hardware set beats a write-one clear
    wire [53:0] flag_clr = {wr_flag_hi ? hwdata[intc_pkg::HI_WIDTH-1:0]
                                       : 22'h000000,
                            wr_flag_lo ? hwdata : 32'h00000000};
    assign flag_next = ((flag_reg & ~flag_clr) | irq_event)
                       & intc_pkg::SRC_IMPL;
    assign enable_next = {wr_en_hi ? hwdata[intc_pkg::HI_WIDTH-1:0]
                                   : enable_reg[53:32],
                          wr_en_lo ? hwdata : enable_reg[31:0]}
                         & intc_pkg::SRC_IMPL;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_reg   <= 54'h0;
            enable_reg <= 54'h0;
            ctrl_reg   <= intc_pkg::CTRL_RESET;
        end else if (clk_en) begin
            flag_reg   <= flag_next;
            enable_reg <= enable_next;
            if (wr_ctrl) begin
                ctrl_reg <= hwdata[1:0];
            end
        end
    end

    // Interrupt arbitration
    wire        win_found;
    wire [5:0]  win_index;
    wire [2:0]  win_prio;

    prio_arbiter u_arbiter (
        .pending    (flag_reg & enable_reg),
        .prio_words (prio_masked),
        .found      (win_found),
        .win_index  (win_index),
        .win_prio   (win_prio)
    );

    wire [3:0] win_level = {1'b0, win_prio};
    // Level seven or any trap level in the core masks every source
    wire irq_go = win_found && win_level > cpu_priority_level;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_valid_reg  <= 1'b0;
            irq_vector_reg <= 6'h00;
            irq_level_reg  <= 4'h0;
        end else if (clk_en) begin
            irq_valid_reg  <= irq_go;
            irq_vector_reg <= win_index + intc_pkg::VEC_BASE;
            irq_level_reg  <= win_level;
        end
    end

    // Trap conditions
    wire math_cond = div_by_zero
        | (ctrl_reg[intc_pkg::CTRL_OVF31_BIT] && |acc_ovf31
           && !guard_bits_used)
        | (ctrl_reg[intc_pkg::CTRL_OVF39_BIT] && |acc_ovf39
           && saturation_disabled)
        | shift_overrange;
    wire dual_space_err = multiply_accumulate_class
                          && (x_access_in_y || y_access_in_x);
    wire addr_cond = misaligned_word | unimpl_data_fetch
        | unimpl_prog_fetch | vector_space_fetch
        | dual_space_err
        | jump_to_unimpl | exec_unimpl_pc
        | invalid_vector;
    wire trap_lockout = math_cond && addr_cond;

    // Ack retires only the trap the core was shown
    wire ack_math = trap_ack && trap_valid_reg
                    && trap_vector_reg == intc_pkg::MATH_TRAP_VEC;
    wire ack_addr = trap_ack && trap_valid_reg
                    && trap_vector_reg == intc_pkg::ADDR_TRAP_VEC;
    assign math_pend_next = (math_pend_reg && !ack_math) || math_cond;
    assign addr_pend_next = (addr_pend_reg && !ack_addr) || addr_cond;
    wire any_pend_next = math_pend_next || addr_pend_next;
    wire [5:0] trap_vec_next = addr_pend_next ? intc_pkg::ADDR_TRAP_VEC
                                              : intc_pkg::MATH_TRAP_VEC;

    // Presentation waits for the faulting instruction to finish
    always_comb begin
        trap_state_next = trap_state_reg;
        unique case (trap_state_reg)
            intc_pkg::TRAP_IDLE: begin
                if (any_pend_next) begin
                    trap_state_next = insn_boundary ? intc_pkg::TRAP_SHOW
                                                    : intc_pkg::TRAP_WAIT;
                end
            end
            intc_pkg::TRAP_WAIT: begin
                if (insn_boundary) begin
                    trap_state_next = intc_pkg::TRAP_SHOW;
                end
            end
            intc_pkg::TRAP_SHOW: begin
                // New conditions during processing keep it shown
                if (!any_pend_next) begin
                    trap_state_next = intc_pkg::TRAP_IDLE;
                end
            end
            default: begin
                trap_state_next = intc_pkg::TRAP_IDLE;
            end
        endcase
    end

    assign trap_stat_next =
        (trap_stat_reg & ~(wr_stat ? hwdata[1:0] : 2'h0))
        | {addr_cond, math_cond};

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            trap_state_reg  <= intc_pkg::TRAP_IDLE;
            math_pend_reg   <= 1'b0;
            addr_pend_reg   <= 1'b0;
            trap_valid_reg  <= 1'b0;
            trap_vector_reg <= intc_pkg::MATH_TRAP_VEC;
            trap_stat_reg   <= 2'h0;
        end else if (clk_en) begin
            trap_state_reg  <= trap_state_next;
            math_pend_reg   <= math_pend_next;
            addr_pend_reg   <= addr_pend_next;
            // Not gated by the CPU level: traps cannot be masked
            trap_valid_reg  <= trap_state_next == intc_pkg::TRAP_SHOW;
            trap_vector_reg <= trap_vec_next;
            trap_stat_reg   <= trap_stat_next;
        end
    end

    // Reset sources; the core itself restarts from address zero
    wire [5:0] cause_now = {soft_reset_op,
                            trap_lockout,
                            brownout_reset,
                            illegal_op_exec && !illegal_op_flushed,
                            uninit_wreg_pointer,
                            watchdog_timeout};
    assign cause_next = (cause_reg & ~(wr_cause ? hwdata[5:0] : 6'h00))
                        | cause_now;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reset_request_reg <= 1'b0;
            cause_reg         <= 6'h00;
        end else if (clk_en) begin
            reset_request_reg <= |cause_now;
            cause_reg         <= cause_next;
        end
    end

    assign hreadyout     = hreadyout_reg;
    assign hresp         = hresp_reg;
    assign hrdata        = hrdata_reg;
    assign irq_valid     = irq_valid_reg;
    assign irq_vector    = irq_vector_reg;
    assign irq_level     = irq_level_reg;
    assign trap_valid    = trap_valid_reg;
    assign trap_vector   = trap_vector_reg;
    assign trap_level    = intc_pkg::trap_level_of(trap_vector_reg);
    assign reset_request = reset_request_reg;

endmodule : interrupt_trap_priority

// ### core/prio_arbiter.sv
`timescale 1ns/1ps
module prio_arbiter (
    input  wire logic [53:0]  pending,
    input  wire logic [223:0] prio_words,
    output logic              found,
    output logic [5:0]        win_index,
    output logic [2:0]        win_prio
);

    // Scan from the highest natural order downward so the lower number wins
    always_comb begin
        logic [2:0] p;
        p         = 3'h0;
        found     = 1'b0;
        win_index = 6'h00;
        win_prio  = 3'h0;
        for (int i = intc_pkg::NUM_SRC - 1; i >= 0; i--) begin
            p = prio_words[i*4 +: 3];
            if (pending[i] && intc_pkg::SRC_IMPL[i] && p != 3'h0
                && p >= win_prio) begin
                found     = 1'b1;
                win_prio  = p;
                win_index = 6'(i);
            end
        end
    end

endmodule : prio_arbiter

// ### testbench/core_model.sv
`timescale 1ns/1ps
module core_model (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic slow,
    input  wire logic ack_en,
    input  wire logic trap_valid,
    output logic      insn_boundary,
    output logic      trap_ack
);
    logic [1:0] step_reg;

    // Slow mode stretches each instruction to four cycles
    assign insn_boundary = !slow || step_reg == 2'h3;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            step_reg <= 2'h0;
            trap_ack <= 1'b0;
        end else begin
            step_reg <= step_reg + 2'h1;
            // Gaps between acks let a nested trap show on its own
            trap_ack <= trap_valid && ack_en && !trap_ack;
        end
    end
endmodule : core_model

// ### testbench/interrupt_trap_priority_monitor.sv
`timescale 1ns/1ps
module interrupt_trap_priority_monitor (
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire logic       clk_en,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic [3:0] cpu_priority_level,
    input wire logic       insn_boundary,
    input wire logic       watchdog_timeout,
    input wire logic       uninit_wreg_pointer,
    input wire logic       illegal_op_exec,
    input wire logic       illegal_op_flushed,
    input wire logic       div_by_zero,
    input wire logic       misaligned_word,
    input wire logic       irq_valid,
    input wire logic [5:0] irq_vector,
    input wire logic [3:0] irq_level,
    input wire logic       trap_valid,
    input wire logic [5:0] trap_vector,
    input wire logic [3:0] trap_level,
    input wire logic       reset_request
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // An early cause shows on the boundary edge itself, as a coincident cause does
    sequence s_boundary_seen;
        $past(insn_boundary) || $past(insn_boundary, 2);
    endsequence

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus response not okay");
    a_trap_level: assert property (
        trap_valid |-> trap_level == 4'h8 + trap_vector[3:0])
        else $error("trap level not eight plus vector");
    a_trap_boundary: assert property (
        $rose(trap_valid) |-> s_boundary_seen)
        else $error("trap shown before instruction end");
    a_div_trap: assert property (
        clk_en && div_by_zero && insn_boundary |=> trap_valid)
        else $error("divide by zero not trapped");
    a_lockout_reset: assert property (
        clk_en && div_by_zero && misaligned_word |=> reset_request)
        else $error("trap lockout without reset");
    a_wdog_reset: assert property (
        clk_en && watchdog_timeout |=> reset_request)
        else $error("watchdog without reset");
    a_uninit_reset: assert property (
        clk_en && uninit_wreg_pointer |=> reset_request)
        else $error("unwritten pointer without reset");
    a_illegal_reset: assert property (
        clk_en && illegal_op_exec && !illegal_op_flushed |=> reset_request)
        else $error("executed illegal opcode without reset");
    a_irq_above_cpu: assert property (
        irq_valid |-> irq_level > $past(cpu_priority_level))
        else $error("request not above core level");
    a_irq_level_range: assert property (
        irq_valid |-> irq_level inside {[4'h1:4'h7]})
        else $error("request level out of range");
    a_irq_vector_map: assert property (
        irq_valid |-> irq_vector inside {[6'h08:6'h32]})
        else $error("vector outside source range");
endmodule : interrupt_trap_priority_monitor

// ### testbench/interrupt_trap_priority_tb_top.sv
`timescale 1ns/1ps
module interrupt_trap_priority_tb_top;
    localparam logic [17:0] trap_pat [18] = '{18'h1, 18'h2, 18'h4, 18'h8,
        18'h20010, 18'h20020, 18'h40, 18'h80, 18'h100, 18'h200, 18'h400,
        18'h800, 18'h1000, 18'hA000, 18'hC000, 18'h10004, 18'h10, 18'h2000};
    localparam logic [5:0] rst_pat [7] = '{6'h1, 6'h2, 6'h4, 6'h8, 6'h10,
        6'h24, 6'h0};
    localparam logic [5:0] rst_cause [7] = '{6'h1, 6'h2, 6'h4, 6'h8,
        6'h20, 6'h0, 6'h10};
    logic        ref_clk, reset_n, hwrite, hreadyout, hresp, slow, ack_en;
    logic        trap_ack, insn_boundary, irq_valid, trap_valid, rst_req;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [53:0] irq_event, ev, en;
    logic [3:0]  cpu, irq_level, trap_level;
    logic [5:0]  irq_vector, trap_vector, rc;
    logic [17:0] tc;
    logic [10:0] ex;
    logic [31:0] pw [7];
    int          err_count, checks_done, seed, acks, n;

    interrupt_trap_priority uut (.ref_clk(ref_clk), .reset_n(reset_n),
        .clk_en(1'b1), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .irq_event(irq_event), .cpu_priority_level(cpu),
        .insn_boundary(insn_boundary), .trap_ack(trap_ack),
        .watchdog_timeout(rc[0]), .uninit_wreg_pointer(rc[1]),
        .illegal_op_exec(rc[2]), .brownout_reset(rc[3]),
        .soft_reset_op(rc[4]), .illegal_op_flushed(rc[5]),
        .div_by_zero(tc[0]), .shift_overrange(tc[1]), .acc_ovf31(tc[3:2]),
        .acc_ovf39(tc[5:4]), .misaligned_word(tc[6]),
        .unimpl_data_fetch(tc[7]), .unimpl_prog_fetch(tc[8]),
        .vector_space_fetch(tc[9]), .jump_to_unimpl(tc[10]),
        .exec_unimpl_pc(tc[11]), .invalid_vector(tc[12]),
        .x_access_in_y(tc[13]), .y_access_in_x(tc[14]),
        .multiply_accumulate_class(tc[15]), .guard_bits_used(tc[16]),
        .saturation_disabled(tc[17]), .irq_valid(irq_valid),
        .irq_vector(irq_vector), .irq_level(irq_level),
        .trap_valid(trap_valid), .trap_vector(trap_vector),
        .trap_level(trap_level), .reset_request(rst_req));
    core_model core (.ref_clk(ref_clk), .reset_n(reset_n), .slow(slow),
        .ack_en(ack_en), .trap_valid(trap_valid),
        .insn_boundary(insn_boundary), .trap_ack(trap_ack));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic edge_rdy;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
    endtask : edge_rdy

    // Single word transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        n = 0;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= intc_pkg::HTRANS_NONSEQ;
        edge_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        edge_rdy();
        rd = hrdata;
        if (n >= 40) begin
            err_count++;
            wrap_up();
        end
    endtask : bus

    function automatic logic impl(input int s);
        return s < 39 || s == 41 || s == 42;
    endfunction : impl

    function automatic logic [31:0] pmask(input int w);
        logic [31:0] m;
        m = 32'h0;
        for (int k = 0; k < 8; k++) if (impl(w * 8 + k)) m[k*4 +: 3] = 3'h7;
        return m;
    endfunction : pmask

    // Highest level wins, lowest number on a tie, level zero never
    function automatic logic [10:0] exp_win(input logic [53:0] p);
        logic [2:0] bp;
        logic [5:0] bi;
        bp = 3'h0;
        bi = 6'h0;
        for (int s = 0; s < 54; s++) begin
            if (p[s] && impl(s) && pw[s/8][(s%8)*4 +: 3] > bp) begin
                bp = pw[s/8][(s%8)*4 +: 3];
                bi = 6'(s);
            end
        end
        return {{1'b0, bp} > cpu, bi + 6'h08, 1'b0, bp};
    endfunction : exp_win

    task automatic reset_check;
        reset_n <= 1'b0;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        for (int w = 0; w < 7; w++) begin
            bus(0, intc_pkg::OFS_PRIO_BASE + 8'(w * 4), 32'h0);
            chk(rd, 32'h44444444 & pmask(w));
        end
        bus(0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        $display("test reset done");
    endtask : reset_check

    initial begin
        #1ms;
        err_count++;
        wrap_up();
    end

    initial begin
        {hwrite, slow, htrans, haddr, hwdata, irq_event, cpu, tc, rc} = '0;
        {reset_n, ack_en, seed, err_count, checks_done} =
            {2'b01, 32'd93, 64'd0};
        reset_check();
        for (int k = 0; k < 40; k++) begin
            en = {$random(seed), $random(seed)};
            ev = {$random(seed), $random(seed)};
            bus(1, intc_pkg::OFS_EN_LO, en[31:0]);
            bus(1, intc_pkg::OFS_EN_HI, {10'h0, en[53:32]});
            for (int w = 0; w < 7; w++) begin
                pw[w] = (k == 0 ? 32'h33333333 : $random(seed)) & pmask(w);
                bus(1, intc_pkg::OFS_PRIO_BASE + 8'(w * 4), pw[w]);
            end
            bus(0, intc_pkg::OFS_PRIO_BASE + 8'(k % 7 * 4), 32'h0);
            chk(rd, pw[k % 7]);
            cpu <= 4'(k % 9);
            irq_event <= ev;
            @(posedge ref_clk);
            irq_event <= 54'h0;
            repeat (2) @(posedge ref_clk);
            ex = exp_win(ev & en);
            chk(32'(irq_valid), 32'(ex[10]));
            if (ex[10]) chk({irq_vector, irq_level}, 32'(ex[9:0]));
            bus(0, intc_pkg::OFS_FLAG_HI, 32'h0);
            chk(rd, {10'h0, ev[53:32] & 22'h67F});
            bus(1, intc_pkg::OFS_FLAG_LO, 32'hFFFFFFFF);
            bus(1, intc_pkg::OFS_FLAG_HI, 32'hFFFFFFFF);
        end
        $display("test arbitration done");
        bus(1, intc_pkg::OFS_TRAP_CTRL, 32'h3);
        for (int i = 0; i < 18; i++) begin
            slow <= i[0];
            tc <= trap_pat[i];
            @(posedge ref_clk);
            tc <= 18'h0;
            n = 0;
            while (trap_valid !== 1'b1 && n < 8) begin
                @(posedge ref_clk);
                n++;
            end
            chk(32'(trap_valid), 32'(i < 15));
            if (i < 15) chk(32'(trap_vector), i < 6 ? 32'h3 : 32'h4);
            bus(0, intc_pkg::OFS_TRAP_STAT, 32'h0);
            chk(rd, i < 6 ? 32'h1 : i < 15 ? 32'h2 : 32'h0);
            bus(1, intc_pkg::OFS_TRAP_STAT, 32'h3);
        end
        $display("test trap sources done");
        {slow, ack_en, acks} = '0;
        tc <= 18'h1;
        @(posedge ref_clk);
        tc <= 18'h40;
        @(posedge ref_clk);
        tc <= 18'h0;
        repeat (4) @(posedge ref_clk);
        chk(32'(trap_vector), 32'h4);
        ack_en <= 1'b1;
        n = 0;
        while (trap_valid === 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
            acks += int'(trap_ack);
        end
        chk(acks, 2);
        $display("test nesting done");
        for (int i = 0; i < 7; i++) begin
            rc <= rst_pat[i];
            tc <= i == 6 ? 18'h41 : 18'h0;
            @(posedge ref_clk);
            {rc, tc} <= '0;
            @(posedge ref_clk);
            chk(32'(rst_req), 32'(i != 5));
            bus(0, intc_pkg::OFS_RST_CAUSE, 32'h0);
            chk(rd, 32'(rst_cause[i]));
            bus(1, intc_pkg::OFS_RST_CAUSE, 32'h3F);
        end
        $display("test reset causes done");
        reset_check();
        wrap_up();
    end
endmodule : interrupt_trap_priority_tb_top

bind interrupt_trap_priority interrupt_trap_priority_monitor mon (.*);
